//--- design/sdap_pkg.sv
// Purpose: shared constants, types and bit-order helpers of the serial debug access port
// Assumes: 16-bit words, 8-bit command, 200 MHz mclk
// Notes: command codes and bit order are module parameters defaulting to these values
package sdap_pkg;

  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int unsigned CMD_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W = 5;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h10;

  // ---------------------------------------------------------------
  // command codes and bit order
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam bit MSB_FIRST_DEF = 1'b1;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned MCLK_PERIOD_NS = 5;
  localparam int unsigned SCLK_HALF_NS = 80;
  localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned SCLK_HALF_MIN = 8;
  localparam logic [1:0] PROTO_RST_CYCLES = 2'h2;

  // ---------------------------------------------------------------
  // frame segments
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SEG_CMD, SEG_ADDR, SEG_DATA} sdap_seg_t;

  // ---------------------------------------------------------------
  // bit-order helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] sh_in(input logic msb, input logic [15:0] sr, input logic b);
    sh_in = msb ? {sr[14:0], b} : {b, sr[15:1]};
  endfunction

  function automatic logic [15:0] sh_out(input logic msb, input logic [15:0] sr);
    sh_out = msb ? {sr[14:0], 1'b0} : {1'b0, sr[15:1]};
  endfunction

  function automatic logic out_bit(input logic msb, input logic [15:0] sr);
    out_bit = msb ? sr[15] : sr[0];
  endfunction

endpackage

//--- design/sdap_if.sv
// Purpose: four-wire debug link plus enable between master and device
// Assumes: all wires driven by exactly one end, no tristate
// Notes: master owns the clock
`timescale 1ns/1ps
interface sdap_if;
  logic en;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;

  modport dev (
    input en,
    input cs_n,
    input sclk,
    input mosi,
    output miso
  );

  modport host (
    output en,
    output cs_n,
    output sclk,
    output mosi,
    input miso
  );
endinterface

//--- design/sdap_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: W independent levels
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module sdap_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

//--- design/sdap_dev.sv
// Purpose: device end of the serial debug access port, bridging link words to memory
// Assumes: mclk at least 16x faster than the link clock; memory acks within 8 cycles
// Notes: link pins are synchronised and clock edges found on mclk
`timescale 1ns/1ps
module sdap_dev #(
  parameter bit MSB_FIRST = sdap_pkg::MSB_FIRST_DEF,
  parameter logic [7:0] CMD_RD = sdap_pkg::CMD_READ,
  parameter logic [7:0] CMD_WR = sdap_pkg::CMD_WRITE
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // link
  sdap_if.dev lnk,
  // processor state
  input wire logic cpu_halted_i,
  // memory request
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  // memory answer
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (CMD_RD == CMD_WR) begin : g_bad_cmd
    $error("read and write command codes must differ");
  end

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  logic en_s;
  logic cs_n_s;
  logic sclk_s;
  logic mosi_s;

  sdap_sync #(
    .W(4),
    .RST_VAL(4'h4)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i({lnk.en, lnk.cs_n, lnk.sclk, lnk.mosi}),
    .q_o({en_s, cs_n_s, sclk_s, mosi_s})
  );

  // ---------------------------------------------------------------
  // edge detection and decode
  // ---------------------------------------------------------------
  logic sclk_d_r;
  sdap_pkg::sdap_seg_t seg_r;
  logic [4:0] bit_cnt_r;
  logic [15:0] rx_sr_r;
  logic [15:0] tx_sr_r;
  logic [15:0] rd_buf_r;
  logic [15:0] addr_r;
  logic op_rd_r;
  logic op_wr_r;
  logic rd_pend_r;
  logic miso_r;
  logic mem_req_r;
  logic mem_we_r;
  logic [15:0] mem_addr_r;
  logic [15:0] mem_wdata_r;

  wire active = en_s & ~cs_n_s;
  wire sclk_rise = active & sclk_s & ~sclk_d_r;
  wire sclk_fall = active & ~sclk_s & sclk_d_r;
  wire [4:0] word_bits = (seg_r == sdap_pkg::SEG_CMD) ? sdap_pkg::CMD_BITS : sdap_pkg::WORD_BITS;
  wire word_done = sclk_rise & (bit_cnt_r == word_bits - 5'h01);
  wire [15:0] rx_nxt = sdap_pkg::sh_in(MSB_FIRST, rx_sr_r, mosi_s);
  wire [7:0] cmd_w = MSB_FIRST ? rx_nxt[7:0] : rx_nxt[15:8];
  wire cmd_done = word_done & (seg_r == sdap_pkg::SEG_CMD);
  wire addr_done = word_done & (seg_r == sdap_pkg::SEG_ADDR);
  wire data_done = word_done & (seg_r == sdap_pkg::SEG_DATA);
  wire wr_fire = data_done & op_wr_r;
  wire rd_word_start = sclk_fall & (seg_r == sdap_pkg::SEG_DATA) & op_rd_r & (bit_cnt_r == 5'h00);
  wire rd_bit_next = sclk_fall & (seg_r == sdap_pkg::SEG_DATA) & op_rd_r & (bit_cnt_r != 5'h00);
  wire [15:0] addr_inc = addr_r + 16'h0001;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  // ---------------------------------------------------------------
  // frame sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      seg_r <= sdap_pkg::SEG_CMD;
      bit_cnt_r <= 5'h00;
      rx_sr_r <= 16'h0000;
    end else if (!active) begin
      seg_r <= sdap_pkg::SEG_CMD;
      bit_cnt_r <= 5'h00;
    end else if (sclk_rise) begin
      rx_sr_r <= rx_nxt;
      if (word_done) begin
        bit_cnt_r <= 5'h00;
        unique case (seg_r)
          sdap_pkg::SEG_CMD: seg_r <= sdap_pkg::SEG_ADDR;
          sdap_pkg::SEG_ADDR: seg_r <= sdap_pkg::SEG_DATA;
          sdap_pkg::SEG_DATA: seg_r <= sdap_pkg::SEG_DATA;
          default: seg_r <= sdap_pkg::SEG_CMD;
        endcase
      end else begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // command decode and address tracking
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      op_rd_r <= 1'b0;
      op_wr_r <= 1'b0;
      addr_r <= 16'h0000;
    end else begin
      if (cmd_done) begin
        op_rd_r <= (cmd_w == CMD_RD);
        op_wr_r <= (cmd_w == CMD_WR);
      end
      if (addr_done) begin
        addr_r <= rx_nxt;
      end else if (wr_fire | rd_word_start) begin
        addr_r <= addr_inc;
      end
    end
  end

  // ---------------------------------------------------------------
  // memory requests
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= 16'h0000;
      mem_wdata_r <= 16'h0000;
    end else begin
      mem_req_r <= 1'b0;
      if (wr_fire) begin
        mem_req_r <= 1'b1;
        mem_we_r <= 1'b1;
        mem_addr_r <= addr_r;
        mem_wdata_r <= rx_nxt;
      end else if (addr_done & op_rd_r) begin
        mem_req_r <= 1'b1;
        mem_we_r <= 1'b0;
        mem_addr_r <= rx_nxt;
      end else if (rd_word_start) begin
        mem_req_r <= 1'b1;
        mem_we_r <= 1'b0;
        mem_addr_r <= addr_inc;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rd_pend_r <= 1'b0;
      rd_buf_r <= 16'h0000;
    end else begin
      if (mem_req_r & ~mem_we_r) begin
        rd_pend_r <= 1'b1;
      end else if (mem_ack_i & rd_pend_r) begin
        rd_pend_r <= 1'b0;
        rd_buf_r <= mem_rdata_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // read data output
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      miso_r <= 1'b0;
      tx_sr_r <= 16'h0000;
    end else if (!(~cs_n_s & en_s)) begin
      miso_r <= cpu_halted_i;
    end else if (rd_word_start) begin
      miso_r <= sdap_pkg::out_bit(MSB_FIRST, rd_buf_r);
      tx_sr_r <= sdap_pkg::sh_out(MSB_FIRST, rd_buf_r);
    end else if (rd_bit_next) begin
      miso_r <= sdap_pkg::out_bit(MSB_FIRST, tx_sr_r);
      tx_sr_r <= sdap_pkg::sh_out(MSB_FIRST, tx_sr_r);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign lnk.miso = miso_r;
  assign mem_req_o = mem_req_r;
  assign mem_we_o = mem_we_r;
  assign mem_addr_o = mem_addr_r;
  assign mem_wdata_o = mem_wdata_r;

endmodule

//--- design/sdap_host.sv
// Purpose: master end of the serial debug access port
// Assumes: one transaction at a time started by go_i
// Notes: link clock derived from mclk by a half-period divider
`timescale 1ns/1ps
module sdap_host #(
  parameter bit MSB_FIRST = sdap_pkg::MSB_FIRST_DEF,
  parameter logic [7:0] CMD_RD = sdap_pkg::CMD_READ,
  parameter logic [7:0] CMD_WR = sdap_pkg::CMD_WRITE,
  parameter int unsigned HALF_DIV = sdap_pkg::SCLK_HALF_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // link
  sdap_if.host lnk,
  // request
  input wire logic go_i,
  input wire logic wr_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] nwords_i,
  input wire logic [15:0] wdata_i,
  // answer
  output logic wdata_take_o,
  output logic [15:0] rdata_o,
  output logic rdata_valid_o,
  output logic busy_o,
  output logic done_o
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (HALF_DIV < sdap_pkg::SCLK_HALF_MIN || HALF_DIV > 255) begin : g_bad_div
    $error("HALF_DIV out of range 8..255");
  end

  typedef enum logic [1:0] {HS_IDLE, HS_RST, HS_XFER, HS_END} sdap_hst_t;

  // ---------------------------------------------------------------
  // state and divider
  // ---------------------------------------------------------------
  sdap_hst_t st_r;
  logic [7:0] div_r;
  logic [1:0] rcnt_r;
  sdap_pkg::sdap_seg_t seg_r;
  logic [4:0] bit_cnt_r;
  logic [15:0] tx_sr_r;
  logic [15:0] rx_sr_r;
  logic [15:0] left_r;
  logic [15:0] addr_r;
  logic wr_r;
  logic en_r;
  logic cs_n_r;
  logic sclk_r;
  logic mosi_r;
  logic take_r;
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic busy_r;
  logic done_r;
  logic miso_s;

  sdap_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(lnk.miso),
    .q_o(miso_s)
  );

  wire tick = (div_r == 8'(HALF_DIV - 1));
  wire [15:0] cmd_word = MSB_FIRST ? {(wr_r ? CMD_WR : CMD_RD), 8'h00}
                                   : {8'h00, (wr_r ? CMD_WR : CMD_RD)};
  wire [4:0] word_bits = (seg_r == sdap_pkg::SEG_CMD) ? sdap_pkg::CMD_BITS : sdap_pkg::WORD_BITS;
  wire word_end = (bit_cnt_r == word_bits);
  wire last_word = (left_r == 16'h0001);
  wire [15:0] nxt_word = (seg_r == sdap_pkg::SEG_CMD) ? addr_r : wdata_i;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || st_r == HS_IDLE || tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // transaction sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_r <= HS_IDLE;
      en_r <= 1'b0;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      mosi_r <= 1'b0;
      rcnt_r <= 2'h0;
      seg_r <= sdap_pkg::SEG_CMD;
      bit_cnt_r <= 5'h00;
      tx_sr_r <= 16'h0000;
      rx_sr_r <= 16'h0000;
      left_r <= 16'h0000;
      addr_r <= 16'h0000;
      wr_r <= 1'b0;
      take_r <= 1'b0;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      en_r <= 1'b1;
      take_r <= 1'b0;
      rvalid_r <= 1'b0;
      done_r <= 1'b0;
      unique case (st_r)
        HS_IDLE: begin
          if (go_i) begin
            st_r <= HS_RST;
            busy_r <= 1'b1;
            wr_r <= wr_i;
            addr_r <= addr_i;
            left_r <= (nwords_i == 16'h0000) ? 16'h0001 : nwords_i;
            rcnt_r <= 2'h0;
          end
        end
        HS_RST: begin
          if (tick) begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              rcnt_r <= rcnt_r + 2'h1;
              if (rcnt_r == sdap_pkg::PROTO_RST_CYCLES - 2'h1) begin
                cs_n_r <= 1'b0;
                seg_r <= sdap_pkg::SEG_CMD;
                bit_cnt_r <= 5'h00;
                mosi_r <= sdap_pkg::out_bit(MSB_FIRST, cmd_word);
                tx_sr_r <= sdap_pkg::sh_out(MSB_FIRST, cmd_word);
                st_r <= HS_XFER;
              end
            end
          end
        end
        HS_XFER: begin
          if (tick && !sclk_r) begin
            sclk_r <= 1'b1;
            rx_sr_r <= sdap_pkg::sh_in(MSB_FIRST, rx_sr_r, miso_s);
            bit_cnt_r <= bit_cnt_r + 5'h01;
          end else if (tick) begin
            sclk_r <= 1'b0;
            if (word_end) begin
              bit_cnt_r <= 5'h00;
              if (seg_r == sdap_pkg::SEG_DATA) begin
                rdata_r <= rx_sr_r;
                rvalid_r <= ~wr_r;
              end
              if (seg_r == sdap_pkg::SEG_DATA && last_word) begin
                cs_n_r <= 1'b1;
                st_r <= HS_END;
              end else begin
                if (seg_r == sdap_pkg::SEG_DATA) begin
                  left_r <= left_r - 16'h0001;
                end
                if (seg_r != sdap_pkg::SEG_CMD) begin
                  take_r <= wr_r;
                end
                seg_r <= (seg_r == sdap_pkg::SEG_CMD) ? sdap_pkg::SEG_ADDR
                                                      : sdap_pkg::SEG_DATA;
                mosi_r <= sdap_pkg::out_bit(MSB_FIRST, nxt_word);
                tx_sr_r <= sdap_pkg::sh_out(MSB_FIRST, nxt_word);
              end
            end else begin
              mosi_r <= sdap_pkg::out_bit(MSB_FIRST, tx_sr_r);
              tx_sr_r <= sdap_pkg::sh_out(MSB_FIRST, tx_sr_r);
            end
          end
        end
        HS_END: begin
          done_r <= 1'b1;
          busy_r <= 1'b0;
          st_r <= HS_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign lnk.en = en_r;
  assign lnk.cs_n = cs_n_r;
  assign lnk.sclk = sclk_r;
  assign lnk.mosi = mosi_r;
  assign wdata_take_o = take_r;
  assign rdata_o = rdata_r;
  assign rdata_valid_o = rvalid_r;
  assign busy_o = busy_r;
  assign done_o = done_r;

endmodule

//--- bench/sdap_chk.sv
// Purpose: link checker for the serial debug access port
// Assumes: host divider of 8 mclk per half period
// Notes: watches the interface wires and the processor state input only
`timescale 1ns/1ps
module sdap_chk (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // link
  input wire logic en,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  // processor state
  input wire logic cpu_halted_i
);
  // ---------------------------------------------------------------
  // edge and count helpers
  // ---------------------------------------------------------------
  logic sclk_d_r;
  logic [7:0] sel_age_r;
  logic [3:0] fall_age_r;
  logic [3:0] rise_hi_r;
  logic [15:0] rise_lo_r;
  wire sclk_rise = sclk && !sclk_d_r;
  wire sclk_fall = !sclk && sclk_d_r;
  wire [7:0] sel_age_nxt = (cs_n || !en) ? 8'h00 : sel_age_r + {7'h00, sel_age_r != 8'hFF};
  wire [3:0] fall_age_nxt = sclk_fall ? 4'h0 : fall_age_r + {3'h0, fall_age_r != 4'hF};
  wire [3:0] rise_hi_nxt = !cs_n ? 4'h0 : rise_hi_r + {3'h0, sclk_rise && rise_hi_r != 4'hF};
  wire [15:0] rise_lo_nxt = cs_n ? 16'h0000 : rise_lo_r + {15'h0000, sclk_rise};

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sclk_d_r <= 1'b0;
      sel_age_r <= 8'h00;
      fall_age_r <= 4'h0;
      rise_hi_r <= 4'h0;
      rise_lo_r <= 16'h0000;
    end else begin
      sclk_d_r <= sclk;
      sel_age_r <= sel_age_nxt;
      fall_age_r <= fall_age_nxt;
      rise_hi_r <= rise_hi_nxt;
      rise_lo_r <= rise_lo_nxt;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence half_hold;
    $stable(sclk) [*7];
  endsequence

  sequence idle_run;
    (cs_n && $stable(cpu_halted_i)) [*6];
  endsequence

  en_before_sel_a: assert property ($fell(cs_n) |-> $past(en))
    else $error("select fell with enable low");
  sel_holds_en_a: assert property (!cs_n |-> en)
    else $error("enable low inside a frame");
  sel_clk_low_a: assert property ($changed(cs_n) |-> !sclk)
    else $error("select moved with clock high");
  proto_reset_a: assert property ($fell(cs_n) |-> rise_hi_r == 4'h2)
    else $error("frame not preceded by two clocks");
  frame_len_a: assert property ($rose(cs_n) |->
    rise_lo_r >= 16'h0028 && rise_lo_r[3:0] == 4'h8)
    else $error("frame length not 24 plus whole words");
  mosi_setup_a: assert property (sclk_rise |-> mosi == $past(mosi, 4))
    else $error("data in moved close to rising clock");
  miso_on_fall_a: assert property ($changed(miso) && sel_age_r >= 8'h08 |->
    fall_age_r <= 4'h5)
    else $error("data out moved away from falling clock");
  idle_level_a: assert property (idle_run |-> miso == cpu_halted_i)
    else $error("deselected data out not processor state");
  clk_half_a: assert property ($changed(sclk) |=> half_hold)
    else $error("link clock half period short");
endmodule

//--- bench/test_serial_debug_access_port.sv
// Purpose: self-checking bench joining host and device ends
// Assumes: host divider 8, memory answers reads after 3 cycles
// Notes: host reset mid-frame stands in for an aborted transfer
`timescale 1ns/1ps
module test_serial_debug_access_port;
  logic mclk_i = 1'b0;
  logic host_rst_n = 1'b0;
  logic dev_rst_n = 1'b0;
  logic cpu_halted = 1'b0;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] nwords = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wdata_take, rdata_valid, busy, done, mem_req, mem_we;
  logic [15:0] rdata, mem_addr, mem_wdata, rd_addr;
  logic mem_ack = 1'b0;
  logic [15:0] mem_rdata = 16'h0000;
  logic [1:0] ack_cnt = 2'h0;
  logic [15:0] wbuf[0:8];
  logic [15:0] wr_a[$];
  logic [15:0] wr_d[$];
  logic [15:0] rd_q[$];
  int widx = 0;
  int bad_count = 0;
  int total_checks = 0;

  initial forever #2.5 mclk_i = ~mclk_i;

  sdap_if lnk ();
  sdap_host #(.HALF_DIV(8)) u_sdap_host (.mclk_i(mclk_i), .rst_n_i(host_rst_n), .lnk(lnk.host),
    .go_i(go), .wr_i(wr), .addr_i(addr), .nwords_i(nwords), .wdata_i(wdata),
    .wdata_take_o(wdata_take), .rdata_o(rdata), .rdata_valid_o(rdata_valid), .busy_o(busy),
    .done_o(done));
  sdap_dev u_sdap_dev (.mclk_i(mclk_i), .rst_n_i(dev_rst_n), .lnk(lnk.dev),
    .cpu_halted_i(cpu_halted), .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata));
  sdap_chk u_sdap_chk (.mclk_i(mclk_i), .rst_n_i(host_rst_n), .en(lnk.en), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .mosi(lnk.mosi), .miso(lnk.miso), .cpu_halted_i(cpu_halted));

  function automatic logic [15:0] pat(input logic [15:0] a);
    pat = a ^ 16'h5A5A;
  endfunction

  // ---------------------------------------------------------------
  // memory model and user-side feeders
  // ---------------------------------------------------------------
  always @(posedge mclk_i) begin
    mem_ack <= 1'b0;
    if (ack_cnt != 2'h0) ack_cnt <= ack_cnt - 2'h1;
    if (ack_cnt == 2'h1) begin
      mem_ack <= 1'b1;
      mem_rdata <= pat(rd_addr);
    end
    if (mem_req === 1'b1 && mem_we === 1'b1) begin
      wr_a.push_back(mem_addr);
      wr_d.push_back(mem_wdata);
    end
    if (mem_req === 1'b1 && mem_we === 1'b0) begin
      rd_addr <= mem_addr;
      ack_cnt <= 2'h3;
    end
    if (go === 1'b1) begin
      widx <= 0;
      wdata <= wbuf[0];
    end else if (wdata_take === 1'b1) begin
      widx <= widx + 1;
      wdata <= wbuf[widx + 1];
    end
    if (rdata_valid === 1'b1) rd_q.push_back(rdata);
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic start(input logic w, input logic [15:0] a, input logic [15:0] n);
    wr_a.delete();
    wr_d.delete();
    rd_q.delete();
    @(posedge mclk_i);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    nwords <= n;
    @(posedge mclk_i);
    go <= 1'b0;
  endtask

  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] n);
    int k;
    start(w, a, n);
    @(posedge mclk_i);
    chk("busy set", 16'h0001, {15'h0000, busy});
    k = 0;
    while (done !== 1'b1 && k < 4000) begin
      @(posedge mclk_i);
      k++;
    end
    chk("done seen", 16'h0001, {15'h0000, done});
    chk("busy clear", 16'h0000, {15'h0000, busy});
    repeat (8) @(posedge mclk_i);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_single_write();
    cpu_halted <= 1'b0;
    wbuf[0] = 16'hA5C3;
    xfer(1'b1, 16'h1234, 16'h0001);
    chk("write count", 16'h0001, 16'(wr_a.size()));
    chk("write addr", 16'h1234, wr_a[0]);
    chk("write data", 16'hA5C3, wr_d[0]);
    chk("idle miso running", 16'h0000, {15'h0000, lnk.miso});
    $display("test single_write done");
  endtask

  task automatic t_block_read();
    cpu_halted <= 1'b1;
    xfer(1'b0, 16'hFFFE, 16'h0003);
    chk("read count", 16'h0003, 16'(rd_q.size()));
    for (int i = 0; i < 3; i++) chk("read word", pat(16'hFFFE + 16'(i)), rd_q[i]);
    chk("idle miso halted", 16'h0001, {15'h0000, lnk.miso});
    $display("test block_read done");
  endtask

  task automatic t_block_write();
    for (int i = 0; i < 4; i++) wbuf[i] = 16'hC0DE ^ 16'(i * 16'h0111);
    xfer(1'b1, 16'h00FF, 16'h0004);
    chk("block count", 16'h0004, 16'(wr_a.size()));
    for (int i = 0; i < 4; i++) chk("block addr", 16'h00FF + 16'(i), wr_a[i]);
    for (int i = 0; i < 4; i++) chk("block data", wbuf[i], wr_d[i]);
    $display("test block_write done");
  endtask

  task automatic t_abort();
    int k;
    cpu_halted <= 1'b0;
    wbuf[0] = 16'h1111;
    wbuf[1] = 16'h2222;
    start(1'b1, 16'h0400, 16'h0002);
    k = 0;
    while (wr_a.size() == 0 && k < 2000) begin
      @(posedge mclk_i);
      k++;
    end
    repeat (128) @(posedge mclk_i);
    host_rst_n <= 1'b0;
    repeat (10) @(posedge mclk_i);
    host_rst_n <= 1'b1;
    repeat (400) @(posedge mclk_i);
    chk("abort writes", 16'h0001, 16'(wr_a.size()));
    wbuf[0] = 16'h3C3C;
    xfer(1'b1, 16'h0500, 16'h0001);
    chk("recover addr", 16'h0500, wr_a[0]);
    chk("recover data", 16'h3C3C, wr_d[0]);
    $display("test abort done");
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk_i);
    bad_count++;
    $display("ERROR watchdog expected finish seen hang");
    end_sim();
  end

  initial begin
    repeat (10) @(posedge mclk_i);
    host_rst_n <= 1'b1;
    dev_rst_n <= 1'b1;
    t_single_write();
    t_block_read();
    t_block_write();
    t_abort();
    end_sim();
  end
endmodule
